// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter, one per bit.
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // A change is only believed once stages two and three agree.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        s1_r[i]      <= 1'b0;
        s2_r[i]      <= 1'b0;
        s3_r[i]      <= 1'b0;
        level_out[i] <= 1'b0;
      end else begin
        s1_r[i] <= pins_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i]) begin
          level_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// ---- rtl/servo_cmd_pkg.sv ----
// Constants for the servo command data set decoder.
package servo_cmd_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int ROM_COPY_NS     = 40000;
  localparam int ROM_COPY_CYC    = (ROM_COPY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROM_COPY_W      = 12;
  localparam int ZC_DLY_SHORT_NS = 4250;
  localparam int ZC_DLY_LONG_NS  = 8500;
  localparam int ZC_DLY_SHORT_CYC = ZC_DLY_SHORT_NS / CLK_PERIOD_NS;
  localparam int ZC_DLY_LONG_CYC  = ZC_DLY_LONG_NS / CLK_PERIOD_NS;
  localparam int ZC_CNT_W        = 10;

  // ---------------------------------------------------------------
  // Serial command framing
  // ---------------------------------------------------------------
  localparam int CMD_LEN  = 24;
  localparam int DATA_W   = 16;
  localparam int SEL_W    = 8;
  localparam logic [7:0] CMD_COEF    = 8'h34;
  localparam logic [7:0] CMD_FSEARCH = 8'h35;
  localparam logic [7:0] CMD_TJUMP   = 8'h36;
  localparam logic [7:0] CMD_SLICE   = 8'h37;

  // ---------------------------------------------------------------
  // Coefficient command sub-decodes (data bits 15..10)
  // ---------------------------------------------------------------
  localparam int TAG_LSB = 10;
  localparam int TAG_W   = 6;
  localparam logic [5:0] TAG_LIMIT  = 6'h3E;
  localparam logic [5:0] TAG_OFFSET = 6'h3D;
  localparam logic [5:0] TAG_TRAV   = 6'h3C;
  localparam int COEF_SEL_BIT = 15;
  localparam int COEF_ADDR_LSB = 8;
  localparam int COEF_ADDR_W   = 7;
  localparam int COEF_VAL_LSB  = 0;
  localparam int COEF_VAL_W    = 8;
  localparam int FOCUS_LSB     = 1;
  localparam int FOCUS_W       = 9;
  localparam int TRAV_LSB      = 0;
  localparam int TRAV_W        = 10;
  localparam int TRAV_RD_W     = 9;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int RATE_HI_BIT   = 15;
  localparam int RATE_LO_BIT   = 14;
  localparam int RATE_FAST_BIT = 7;
  localparam int LIMV_LSB      = 8;
  localparam int LIMV_W        = 6;
  localparam int GAIN_LSB      = 0;
  localparam int GAIN_W        = 7;
  localparam int TJ_ZERO_BIT   = 15;
  localparam int ZC_SEL_BIT    = 14;
  localparam int JUMP_LSB      = 8;
  localparam int JUMP_W        = 6;
  localparam int SURF_BIT      = 7;
  localparam int SLICE_HI_BIT  = 15;
  localparam int SLICE_LO_BIT  = 14;

  localparam logic [2:0] RATE_DEF       = 3'h2;
  localparam logic [5:0] LIMV_DEF       = 6'h18;
  localparam logic [6:0] FGAIN_DEF      = 7'h2D;
  localparam logic [6:0] TGAIN_DEF      = 7'h2E;
  localparam logic [5:0] JUMP_DEF       = 6'h0E;
  localparam logic       ZC_SEL_DEF     = 1'h0;
  localparam logic       SURF_DEF       = 1'h0;
  localparam logic [1:0] SLICE_DEF      = 2'h1;
  localparam logic [8:0] FOCUS_RST      = 9'h000;
  localparam logic [9:0] TRAV_RST       = 10'h000;
endpackage

// ---- rtl/servo_command_data_sets.sv ----
// Serial servo command receiver and data set decoder.
// Contract
// - D15 low writes coefficient address and value.
// - Pattern 111110 loads focus offset limit.
// - Counter mode stops when offset equals limit.
// - Pattern 111101 loads signed focus offset.
// - Pattern 111100 loads ten-bit traverse center.
// - Traverse center reads back low nine bits.
// - Search rate code from bits 15,14,7.
// - Search limit voltage resets to 011000.
// - Focus convergence gain resets to 0101101.
// - Track gain resets 0101110; bit15 zero.
// - Surf jump adds jump voltage to drive.
// - Slice level code bits 15,14, default 01.
// - Bit 14 picks track zero-cross delay.
// - Commands are 24 bits, 16-bit data.
// - Coefficient writes blocked during 40us copy.
`timescale 1ns/10ps
module servo_command_data_sets #(
  parameter int DRIVE_W = 16
) (
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  input  wire logic               ser_clk_pin_in,
  input  wire logic               ser_data_pin_in,
  input  wire logic               ser_latch_pin_in,
  input  wire logic               track_zero_cross_in,
  input  wire logic               focus_count_mode_in,
  input  wire logic               focus_count_tick_in,
  input  wire logic               focus_count_down_in,
  input  wire logic [DRIVE_W-1:0] track_filter_in,
  output logic                    coef_wr_out,
  output logic      [6:0]         coef_addr_out,
  output logic      [7:0]         coef_value_out,
  output logic                    coef_copy_busy_out,
  output logic      [8:0]         focus_offset_limit_bits_out,
  output logic      [8:0]         focus_offset_reg_out,
  output logic      [9:0]         trav_center_reg_out,
  output logic      [8:0]         trav_center_read_out,
  output logic      [2:0]         search_rate_out,
  output logic      [5:0]         search_limit_volt_out,
  output logic      [6:0]         focus_conv_gain_out,
  output logic                    zero_cross_delay_sel_out,
  output logic      [5:0]         jump_voltage_reg_out,
  output logic                    surf_jump_en_out,
  output logic      [6:0]         track_conv_gain_out,
  output logic      [1:0]         slice_level_out,
  output logic                    track_zero_cross_dly_out,
  output logic      [DRIVE_W-1:0] track_drive_out
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] lvl;
  logic       sclk_d_r;
  logic       latch_d_r;
  pin_sync #(.W(4)) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .pins_in     ({track_zero_cross_in, ser_latch_pin_in, ser_data_pin_in, ser_clk_pin_in}),
    .level_out   (lvl)
  );
  wire sclk_rise  = lvl[0] & ~sclk_d_r;
  wire latch_rise = lvl[2] & ~latch_d_r;

  // ---------------------------------------------------------------
  // Command shift register and decode
  // ---------------------------------------------------------------
  localparam int ROM_W = servo_cmd_pkg::ROM_COPY_W;
  logic [servo_cmd_pkg::CMD_LEN-1:0] shift_r;
  logic [ROM_W-1:0]                  copy_cnt_r;
  wire [servo_cmd_pkg::CMD_LEN-1:0] shift_nxt = {shift_r[servo_cmd_pkg::CMD_LEN-2:0], lvl[1]};
  wire [7:0]  sel  = shift_r[servo_cmd_pkg::CMD_LEN-1 -: servo_cmd_pkg::SEL_W];
  wire [15:0] d    = shift_r[servo_cmd_pkg::DATA_W-1:0];
  wire [5:0]  tag  = d[servo_cmd_pkg::TAG_LSB +: servo_cmd_pkg::TAG_W];
  wire        is_coef  = latch_rise && (sel == servo_cmd_pkg::CMD_COEF);
  wire        copy_busy = (copy_cnt_r != ROM_W'(servo_cmd_pkg::ROM_COPY_CYC));
  wire        do_coef  = is_coef && !d[servo_cmd_pkg::COEF_SEL_BIT] && !copy_busy;
  wire        do_limit = is_coef && (tag == servo_cmd_pkg::TAG_LIMIT);
  wire        do_off   = is_coef && (tag == servo_cmd_pkg::TAG_OFFSET);
  wire        do_trav  = is_coef && (tag == servo_cmd_pkg::TAG_TRAV);
  wire        do_fs    = latch_rise && (sel == servo_cmd_pkg::CMD_FSEARCH);
  wire        do_tj    = latch_rise && (sel == servo_cmd_pkg::CMD_TJUMP)
                         && !d[servo_cmd_pkg::TJ_ZERO_BIT];
  wire        do_sl    = latch_rise && (sel == servo_cmd_pkg::CMD_SLICE);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_d_r  <= 1'b0;
      latch_d_r <= 1'b0;
      shift_r   <= '0;
    end else begin
      sclk_d_r  <= lvl[0];
      latch_d_r <= lvl[2];
      if (sclk_rise) begin
        shift_r <= shift_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Coefficient RAM write port and ROM copy window
  // ---------------------------------------------------------------
  // copy window timer
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      copy_cnt_r <= '0;
    end else if (copy_busy) begin
      copy_cnt_r <= copy_cnt_r + 1'b1;
    end
  end
  assign coef_copy_busy_out = copy_busy;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      coef_wr_out    <= 1'b0;
      coef_addr_out  <= '0;
      coef_value_out <= '0;
    end else begin
      coef_wr_out <= do_coef;
      if (do_coef) begin
        coef_addr_out  <= d[servo_cmd_pkg::COEF_ADDR_LSB +: servo_cmd_pkg::COEF_ADDR_W];
        coef_value_out <= d[servo_cmd_pkg::COEF_VAL_LSB +: servo_cmd_pkg::COEF_VAL_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // Focus offset, limit and traverse center
  // ---------------------------------------------------------------
  wire [8:0] new_focus = d[servo_cmd_pkg::FOCUS_LSB +: servo_cmd_pkg::FOCUS_W];
  wire       cnt_run   = focus_count_mode_in && focus_count_tick_in
                         && (focus_offset_reg_out != focus_offset_limit_bits_out);
  wire [8:0] cnt_nxt   = focus_count_down_in ? focus_offset_reg_out - 9'h001
                                             : focus_offset_reg_out + 9'h001;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      focus_offset_limit_bits_out <= servo_cmd_pkg::FOCUS_RST;
      focus_offset_reg_out        <= servo_cmd_pkg::FOCUS_RST;
      trav_center_reg_out         <= servo_cmd_pkg::TRAV_RST;
    end else begin
      if (do_limit) begin
        focus_offset_limit_bits_out <= new_focus;
      end
      if (do_off) begin
        focus_offset_reg_out <= new_focus;
      end else if (cnt_run) begin
        focus_offset_reg_out <= cnt_nxt;
      end
      if (do_trav) begin
        trav_center_reg_out <= d[servo_cmd_pkg::TRAV_LSB +: servo_cmd_pkg::TRAV_W];
      end
    end
  end
  assign trav_center_read_out = trav_center_reg_out[servo_cmd_pkg::TRAV_RD_W-1:0];

  // ---------------------------------------------------------------
  // Focus search, track jump and slice settings
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      search_rate_out          <= servo_cmd_pkg::RATE_DEF;
      search_limit_volt_out    <= servo_cmd_pkg::LIMV_DEF;
      focus_conv_gain_out      <= servo_cmd_pkg::FGAIN_DEF;
      zero_cross_delay_sel_out <= servo_cmd_pkg::ZC_SEL_DEF;
      jump_voltage_reg_out     <= servo_cmd_pkg::JUMP_DEF;
      surf_jump_en_out         <= servo_cmd_pkg::SURF_DEF;
      track_conv_gain_out      <= servo_cmd_pkg::TGAIN_DEF;
      slice_level_out          <= servo_cmd_pkg::SLICE_DEF;
    end else begin
      if (do_fs) begin
        search_rate_out       <= {d[servo_cmd_pkg::RATE_HI_BIT], d[servo_cmd_pkg::RATE_LO_BIT],
                                  d[servo_cmd_pkg::RATE_FAST_BIT]};
        search_limit_volt_out <= d[servo_cmd_pkg::LIMV_LSB +: servo_cmd_pkg::LIMV_W];
        focus_conv_gain_out   <= d[servo_cmd_pkg::GAIN_LSB +: servo_cmd_pkg::GAIN_W];
      end
      if (do_tj) begin
        zero_cross_delay_sel_out <= d[servo_cmd_pkg::ZC_SEL_BIT];
        jump_voltage_reg_out     <= d[servo_cmd_pkg::JUMP_LSB +: servo_cmd_pkg::JUMP_W];
        surf_jump_en_out         <= d[servo_cmd_pkg::SURF_BIT];
        track_conv_gain_out      <= d[servo_cmd_pkg::GAIN_LSB +: servo_cmd_pkg::GAIN_W];
      end
      if (do_sl) begin
        slice_level_out <= {d[servo_cmd_pkg::SLICE_HI_BIT], d[servo_cmd_pkg::SLICE_LO_BIT]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Surf jump drive and delayed zero cross
  // ---------------------------------------------------------------
  // The jump voltage is added as an unsigned magnitude; sign is left to the filter.
  wire [DRIVE_W-1:0] jump_ext = {{(DRIVE_W-servo_cmd_pkg::JUMP_W){1'b0}}, jump_voltage_reg_out};
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      track_drive_out <= '0;
    end else begin
      track_drive_out <= surf_jump_en_out ? track_filter_in + jump_ext : track_filter_in;
    end
  end

  // A level shorter than the delay is swallowed; the counter clears whenever the input matches the output again.
  localparam int ZC_W = servo_cmd_pkg::ZC_CNT_W;
  logic [ZC_W-1:0] zc_cnt_r;
  wire [ZC_W-1:0] zc_last = zero_cross_delay_sel_out
      ? ZC_W'(servo_cmd_pkg::ZC_DLY_LONG_CYC - 1)
      : ZC_W'(servo_cmd_pkg::ZC_DLY_SHORT_CYC - 1);
  wire zc_diff = lvl[3] != track_zero_cross_dly_out;
  // delay of the track zero cross
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      zc_cnt_r                 <= '0;
      track_zero_cross_dly_out <= 1'b0;
    end else if (zc_diff && zc_cnt_r >= zc_last) begin
      zc_cnt_r                 <= '0;
      track_zero_cross_dly_out <= lvl[3];
    end else begin
      zc_cnt_r <= zc_diff ? zc_cnt_r + 1'b1 : '0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_coef_cmd;
    is_coef && !d[15] && !copy_busy;
  endsequence

  a_coef_write_strobe: assert property (s_coef_cmd |=> coef_wr_out &&
    coef_addr_out == $past(d[14:8]) && coef_value_out == $past(d[7:0]))
    else $error("coefficient write not issued");
  a_limit_load_value: assert property (is_coef && d[15:10] == 6'h3E |=>
    focus_offset_limit_bits_out == $past(d[9:1])) else $error("limit not loaded");
  a_count_halt_limit: assert property (!do_off &&
    focus_offset_reg_out == focus_offset_limit_bits_out |=> $stable(focus_offset_reg_out))
    else $error("focus offset counted past limit");
  a_offset_load_value: assert property (is_coef && d[15:10] == 6'h3D |=>
    focus_offset_reg_out == $past(d[9:1])) else $error("offset not loaded");
  a_trav_load_value: assert property (is_coef && d[15:10] == 6'h3C |=>
    trav_center_reg_out == $past(d[9:0])) else $error("traverse center not loaded");
  a_trav_read_bits: assert property (do_trav |=>
    trav_center_read_out == $past(d[8:0])) else $error("readout mismatch");
  a_copy_block_write: assert property (copy_busy |=> !coef_wr_out)
    else $error("coefficient write during copy");
  a_bad_subdecode_ignored: assert property (is_coef && d[15] && d[15:10] != 6'h3E &&
    d[15:10] != 6'h3D && d[15:10] != 6'h3C && !cnt_run |=> $stable(focus_offset_reg_out)
    && $stable(focus_offset_limit_bits_out) && $stable(trav_center_reg_out) && !coef_wr_out)
    else $error("unmatched data word changed state");
  a_tjump_bit_guard: assert property (latch_rise && sel == 8'h36 && d[15] |=>
    $stable(track_conv_gain_out) && $stable(jump_voltage_reg_out))
    else $error("track jump word with bit 15 set accepted");
  a_surf_drive_sum: assert property (surf_jump_en_out && $stable(surf_jump_en_out) |=>
    track_drive_out == DRIVE_W'($past(track_filter_in) + $past(jump_ext)))
    else $error("surf jump sum wrong");
  a_rate_field_load: assert property (do_fs |=>
    search_rate_out == {$past(d[15]), $past(d[14]), $past(d[7])})
    else $error("search rate code wrong");
  a_slice_field_load: assert property (do_sl |=>
    slice_level_out == $past(d[15:14])) else $error("slice code wrong");
endmodule

// ---- tb/servo_host_model.sv ----
// Host model that shifts 24-bit servo commands into the device pins.
`timescale 1ns/10ps
module servo_host_model (
  input  wire logic core_clk_in,
  input  wire logic busy_in,
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      ser_latch_out
);
  initial begin
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_latch_out = 1'b0;
  end

  // Every pin level is held five cycles so the device filter sees it.
  task automatic hold_pins();
    repeat (5) @(posedge core_clk_in);
  endtask

  task automatic send(input logic [7:0] sel, input logic [15:0] data, input bit wait_copy);
    logic [23:0] word;
    word = {sel, data};
    for (int i = 0; i < 5000 && wait_copy && busy_in !== 1'b0; i++) begin
      @(posedge core_clk_in);
    end
    for (int b = 23; b >= 0; b--) begin
      ser_clk_out <= 1'b0;
      ser_data_out <= word[b];
      hold_pins();
      ser_clk_out <= 1'b1;
      hold_pins();
    end
    ser_clk_out <= 1'b0;
    ser_latch_out <= 1'b1;
    hold_pins();
    // The data line no longer holds the last bit once the frame is over.
    ser_latch_out <= 1'b0;
    ser_data_out <= ~word[0];
    hold_pins();
  endtask
endmodule

// ---- tb/test_servo_command_data_sets.sv ----
// Self-checking bench for the servo command data set decoder.
`timescale 1ns/10ps
module test_servo_command_data_sets;
  logic        core_clk_in, rst_in, sclk, sdat, slat, track_zero_cross, cmode, ctick, cdown;
  logic        coef_wr, busy, zc_sel, surf, zc_dly;
  logic [6:0]  caddr, fgain, tgain;
  logic [7:0]  cval;
  logic [8:0]  lim, foff, trd;
  logic [9:0]  trav;
  logic [2:0]  rate;
  logic [5:0]  limv, jump;
  logic [1:0]  slice;
  logic [15:0] filt, drive;
  logic [31:0] r;
  int          seed, n_mismatch, compares, n_pulse, since_rst;
  int          e_caddr, e_cval, e_lim, e_foff, e_trav, e_rate, e_limv, e_fgain;
  int          e_zc, e_jump, e_surf, e_tgain, e_slice, e_pulse, e_tz;

  servo_command_data_sets servo_command_data_sets_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ser_clk_pin_in(sclk),
    .ser_data_pin_in(sdat), .ser_latch_pin_in(slat), .track_zero_cross_in(track_zero_cross),
    .focus_count_mode_in(cmode), .focus_count_tick_in(ctick),
    .focus_count_down_in(cdown), .track_filter_in(filt), .coef_wr_out(coef_wr),
    .coef_addr_out(caddr), .coef_value_out(cval), .coef_copy_busy_out(busy),
    .focus_offset_limit_bits_out(lim), .focus_offset_reg_out(foff),
    .trav_center_reg_out(trav), .trav_center_read_out(trd), .search_rate_out(rate),
    .search_limit_volt_out(limv), .focus_conv_gain_out(fgain),
    .zero_cross_delay_sel_out(zc_sel), .jump_voltage_reg_out(jump),
    .surf_jump_en_out(surf), .track_conv_gain_out(tgain), .slice_level_out(slice),
    .track_zero_cross_dly_out(zc_dly), .track_drive_out(drive));

  servo_host_model servo_host_model_inst (
    .core_clk_in(core_clk_in), .busy_in(busy), .ser_clk_out(sclk),
    .ser_data_out(sdat), .ser_latch_out(slat));

  always #5 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in) begin
    if (coef_wr === 1'b1) n_pulse++;
    if (rst_in !== 1'b0) since_rst = 0;
    else since_rst++;
  end

  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_all();
    chk("coef_count", e_pulse, n_pulse);
    chk("coef_addr", e_caddr, caddr);
    chk("coef_value", e_cval, cval);
    chk("limit", e_lim, lim);
    chk("offset", e_foff, foff);
    chk("trav", e_trav, trav);
    chk("trav_read", e_trav % 512, trd);
    chk("rate", e_rate, rate);
    chk("limv", e_limv, limv);
    chk("fgain", e_fgain, fgain);
    chk("tgain", e_tgain, tgain);
    chk("jump", e_jump, jump);
    chk("surf", e_surf, surf);
    chk("zc_sel", e_zc, zc_sel);
    chk("slice", e_slice, slice);
    chk("drive", e_surf ? (filt + e_jump) % 65536 : filt, drive);
  endtask

  task automatic apply_reset();
    rst_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    {e_caddr, e_cval, e_lim, e_foff, e_trav, e_zc, e_surf} = '0;
    e_rate = 2;
    e_limv = 24;
    e_fgain = 45;
    e_tgain = 46;
    e_jump = 14;
    e_slice = 1;
    // The drive register needs one running edge before it shows the filter input.
    repeat (2) @(posedge core_clk_in);
  endtask

  // Sends one command, updates the model, then compares every result.
  task automatic cmd(input logic [7:0] sel, input logic [15:0] d, input bit wait_copy);
    servo_host_model_inst.send(sel, d, wait_copy);
    if (sel == 8'h34) begin
      if (!d[15] && since_rst >= servo_cmd_pkg::ROM_COPY_CYC) begin
        e_caddr = d[14:8];
        e_cval = d[7:0];
        e_pulse++;
      end
      else if (d[15:10] == 6'h3E) e_lim = d[9:1];
      else if (d[15:10] == 6'h3D) e_foff = d[9:1];
      else if (d[15:10] == 6'h3C) e_trav = d[9:0];
    end
    else if (sel == 8'h35) begin
      e_rate = {d[15:14], d[7]};
      e_limv = d[13:8];
      e_fgain = d[6:0];
    end
    else if (sel == 8'h36 && !d[15]) begin
      e_zc = d[14];
      e_jump = d[13:8];
      e_surf = d[7];
      e_tgain = d[6:0];
    end
    else if (sel == 8'h37) e_slice = d[15:14];
    repeat (8) @(posedge core_clk_in);
    check_all();
  endtask

  task automatic tick(input logic down, input int n);
    cdown <= down;
    repeat (n) begin
      ctick <= 1'b1;
      @(posedge core_clk_in);
      ctick <= 1'b0;
      @(posedge core_clk_in);
    end
  endtask

  initial begin
    repeat (50000) @(posedge core_clk_in);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {core_clk_in, track_zero_cross, cmode, ctick, cdown} = '0;
    rst_in = 1'b1;
    filt = 16'h0000;
    seed = 32'hCEB9;
    e_tz = 0;
    apply_reset();
    check_all();
    chk("busy", 1, busy);
    cmd(8'h34, 16'h1234, 1'b0);
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge core_clk_in);
    chk("busy", 0, busy);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      filt <= r[31:16];
      cmd(8'h34, {1'b0, r[14:0]}, 1'b1);
      cmd(8'h34, {6'h3E, r[9:0]}, 1'b0);
      cmd(8'h34, {6'h3D, r[19:10]}, 1'b0);
      cmd(8'h34, {6'h3C, r[20], r[20:12]}, 1'b0);
      cmd(8'h34, {6'h3F, r[9:0]}, 1'b0);
      cmd(8'h34, {6'h20, r[25:16]}, 1'b0);
      cmd(8'h36, {1'b0, r[14:0]}, 1'b0);
      cmd(8'h36, {1'b1, r[30:16]}, 1'b0);
    end
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      cmd(8'h35, {k[2:1], r[5:0], k[0], r[12:6]}, 1'b0);
      if (k < 4) cmd(8'h37, {k[1:0], r[13:0]}, 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      cmd(8'h36, {1'b0, k[0], 14'h0EAD}, 1'b0);
      e_tz = 1 - e_tz;
      track_zero_cross <= e_tz[0];
      repeat (k ? 800 : 380) @(posedge core_clk_in);
      chk("zc_early", 1 - e_tz, zc_dly);
      repeat (k ? 100 : 90) @(posedge core_clk_in);
      chk("zc_late", e_tz, zc_dly);
    end
    cmd(8'h34, {6'h3E, 9'h005, 1'b0}, 1'b0);
    cmd(8'h34, {6'h3D, 9'h003, 1'b0}, 1'b0);
    cmode <= 1'b1;
    tick(1'b0, 4);
    chk("count_stop", 5, foff);
    tick(1'b1, 2);
    chk("count_hold", 5, foff);
    cmd(8'h34, {6'h3D, 9'h008, 1'b0}, 1'b0);
    tick(1'b1, 2);
    chk("count_down", 6, foff);
    cmode <= 1'b0;
    apply_reset();
    check_all();
    finish_test();
  end
endmodule
